//--- gpio_timer_pkg.sv
// Package for the eight-pin port with its event timer.
// Assumes a classic Wishbone slave with 32-bit data and byte selects.
package gpio_timer_pkg;
  localparam int          NUM_PINS      = 8;
  localparam int          ADDR_W        = 8;
  // Register byte addresses.
  localparam logic [7:0]  OFS_OE        = 8'h00;
  localparam logic [7:0]  OFS_DRIVE     = 8'h04;
  localparam logic [7:0]  OFS_SAMPLE    = 8'h08;
  localparam logic [7:0]  OFS_MODIFY    = 8'h0c;
  localparam logic [7:0]  OFS_TRIGEN    = 8'h10;
  localparam logic [7:0]  OFS_IRQEN     = 8'h14;
  localparam logic [7:0]  OFS_EDGE      = 8'h18;
  localparam logic [7:0]  OFS_FLAGS     = 8'h1c;
  localparam logic [7:0]  OFS_CTRL      = 8'h20;
  localparam logic [7:0]  OFS_TRIGSEL   = 8'h24;
  localparam logic [7:0]  OFS_COUNT     = 8'h28;
  localparam logic [7:0]  OFS_RELOAD    = 8'h2c;
  // Field positions.
  localparam int          SET_LSB       = 0;
  localparam int          CLR_LSB       = 16;
  localparam int          CTRL_EN       = 0;
  localparam int          CTRL_SRC      = 1;
  localparam int          CTRL_STOP     = 2;
  localparam int          CTRL_LEVEL    = 3;
  localparam int          CTRL_POL      = 4;
  localparam int          CTRL_OVF      = 5;
  localparam int          TRIGSEL_W     = 3;
  // Reset and limit values.
  localparam logic [31:0] COUNT_MAX     = 32'hffff_ffff;
  localparam logic [31:0] ZERO32        = 32'h0000_0000;
  localparam logic [7:0]  ZERO8         = 8'h00;
  // Interrupt line numbers toward the processor.
  localparam int          IRQ_LINES     = 6;
  localparam int          IRQ_TIMER     = 4;
  localparam int          IRQ_PORT      = 5;

  // Wishbone request and answer.
  typedef struct packed {
    logic              cyc;
    logic              stb;
    logic              we;
    logic [ADDR_W-1:0] adr;
    logic [3:0]        sel;
    logic [31:0]       dat;
  } wb_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } wb_rsp_t;

  // Timer control fields.
  typedef struct packed {
    logic polarity_select;
    logic level_not_edge;
    logic stop_on_wrap;
    logic count_source_select;
    logic enable;
  } ctrl_t;
endpackage

//--- gpio_timer.sv
// Eight-pin port with edge interrupts, timer triggers and a 32-bit timer.
// Assumes pins arrive asynchronously and a classic Wishbone master drives the bus.
`timescale 1ns/1ps
`default_nettype none

// Register map, all on a 32-bit data bus with byte selects.
// Offset 00: direction, one bit a pin, set means the pin is driven.
// Offset 04: drive level, the value a driven pin shows.
// Offset 08: sampled pin levels, read only; writes are dropped.
// Offset 0c: bit modify, write only; low byte sets, byte two clears.
// Offset 10: trigger enable, lets an input pin feed the timer.
// Offset 14: interrupt enable, lets an input pin raise a flag.
// Offset 18: edge select, one means rising and zero means falling.
// Offset 1c: interrupt flags, cleared as a whole by any read.
// Offset 20: timer control, with the overflow pulse visible in bit five.
// Offset 24: trigger source select, the number of the pin that counts.
// Offset 28: count value, readable and writable at any time.
// Offset 2c: reload value, copied into the count on every wrap.
// Any other offset is answered with zero data and ignores writes.
//
// Bus timing.
// A request is taken at the edge where cyc and stb are high and ack is low.
// Ack follows one cycle later and stands for exactly one cycle.
// Read data stands with ack and is zero in every other cycle.
// A master that keeps stb high after ack is taken again once ack falls.
// Writes land at the taking edge, so a read that follows sees them.
//
// Pin path.
// Every pin passes two flip-flops before anything looks at it.
// Edges come from stages two and three, so a pin change reaches the
// flags and an edge-triggered timer three edges after it happens on the pin; a level trigger takes four.
// A pulse on a pin shorter than one clock period may be missed.
// Pins driven as outputs are still sampled, so the sample register
// shows the driven level for them; software ignores those bits.
//
// Interrupt lines.
// Line four carries the timer overflow as a one-cycle pulse.
// Line five carries the OR of all port flags as a level.
// Lines zero to three belong to other blocks and are held low here.
//
// Timer.
// The count steps every cycle in clock mode and on each active
// trigger in trigger mode, only while the enable bit is one.
// At all ones it takes the reload value instead and pulses overflow.
// With stop on wrap set the enable bit is cleared at that wrap, so
// software sees in the control register that the timer has stopped.
// A software write to the count wins over a step in the same cycle.
//
// Set and clear in one write.
// When one write both sets and clears a bit the clear wins, so a
// careless mask can only switch a pin off, never on.
//
// Trade-offs.
// The synchroniser runs on every pin all the time; it costs a few
// flip-flops but removes any spurious edge when a feature is enabled.
// State is kept in one record so that reset and hold are uniform.

module gpio_timer
  import gpio_timer_pkg::*;
#(
  parameter int N = NUM_PINS
) (
  // Clock and reset.
  input  wire logic            clk_i,
  input  wire logic            rst_n_i,
  // Wishbone slave.
  input  wire wb_req_t         wb_req_i,
  output wb_rsp_t              wb_rsp_o,
  // Pins.
  input  wire logic [N-1:0]    pin_i,
  output logic      [N-1:0]    pin_o,
  output logic      [N-1:0]    pin_oe_o,
  // Interrupt lines to the processor.
  output logic [IRQ_LINES-1:0] irq_o
);

  // Whole module state in one record.
  typedef struct packed {
    logic [N-1:0] sync1;
    logic [N-1:0] sync2;
    logic [N-1:0] sync3;
    logic [N-1:0] pin_output_enable;
    logic [N-1:0] drive_level;
    logic [N-1:0] pin_trigger_enable;
    logic [N-1:0] pin_interrupt_enable;
    logic [N-1:0] pin_edge_select;
    logic [N-1:0] pin_interrupt_flags;
    ctrl_t        ctrl;
    logic [TRIGSEL_W-1:0] trigger_source_select;
    logic [31:0]  count_value;
    logic [31:0]  reload_value;
    logic         overflow;
    logic         ack;
    logic [31:0]  rdata;
  } state_t;

  state_t s_q;
  state_t s_d;

  // Per-pin stable level and edges; the level is stage three alone, the edges compare stages two and three.
  logic [N-1:0] stable;
  logic [N-1:0] rise;
  logic [N-1:0] fall;
  logic [N-1:0] trig_out;

  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_pin
      assign stable[g]   = s_q.sync3[g];
      assign rise[g]     = s_q.sync2[g] & ~s_q.sync3[g];
      assign fall[g]     = ~s_q.sync2[g] & s_q.sync3[g];
      // Only inputs with the trigger bit may feed the timer.
      assign trig_out[g] = s_q.pin_trigger_enable[g] & ~s_q.pin_output_enable[g];
    end
  endgenerate

  // Byte-lane write merge honouring sel, so narrow accesses touch only their lanes.
  // Every writable register except the bit modify one goes through it, so byte and half-word writes behave alike
  // on all of them; the unused upper lanes of narrow registers are dropped.
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  logic        req;
  logic        wr;
  logic        rd;
  logic [31:0] wmask;

  // The request is masked while ack stands, so a held strobe is not taken
  // twice; this is what makes the answer exactly one cycle wide.
  assign req = wb_req_i.cyc & wb_req_i.stb & ~s_q.ack;
  assign wr  = req & wb_req_i.we;
  assign rd  = req & ~wb_req_i.we;

  generate
    for (g = 0; g < 4; g++) begin : g_mask
      assign wmask[g*8 +: 8] = {8{wb_req_i.sel[g]}};
    end
  endgenerate

  // Next-state logic: bus access, pin sampling, flags and timer.
  always_comb begin
    logic [N-1:0]  edge_hit;
    logic [31:0]   wv;
    logic          sel_pin;
    logic          active;
    logic          step;
    logic [N-1:0]  set_m;
    logic [N-1:0]  clr_m;
    s_d      = s_q;
    edge_hit = '0;
    wv       = '0;
    sel_pin  = 1'b0;
    active   = 1'b0;
    step     = 1'b0;
    set_m    = '0;
    clr_m    = '0;

    // Three-stage synchroniser on every pin.
    // Stage one may go metastable; only stages two and three are read further on,
    // and stage three gives the previous level for edge detection.
    s_d.sync1 = pin_i;
    s_d.sync2 = s_q.sync1;
    s_d.sync3 = s_q.sync2;

    // Ack is one cycle and drops in the cycle after it was given.
    s_d.ack   = req;
    s_d.rdata = ZERO32;

    if (wr) begin
      case (wb_req_i.adr)
        OFS_OE: begin
          wv = merge({24'h000000, s_q.pin_output_enable}, wb_req_i.dat, wb_req_i.sel);
          s_d.pin_output_enable = wv[N-1:0];
        end
        OFS_DRIVE: begin
          wv = merge({24'h000000, s_q.drive_level}, wb_req_i.dat, wb_req_i.sel);
          s_d.drive_level = wv[N-1:0];
        end
        OFS_TRIGEN: begin
          wv = merge({24'h000000, s_q.pin_trigger_enable}, wb_req_i.dat, wb_req_i.sel);
          s_d.pin_trigger_enable = wv[N-1:0];
        end
        OFS_IRQEN: begin
          wv = merge({24'h000000, s_q.pin_interrupt_enable}, wb_req_i.dat, wb_req_i.sel);
          s_d.pin_interrupt_enable = wv[N-1:0];
        end
        OFS_EDGE: begin
          wv = merge({24'h000000, s_q.pin_edge_select}, wb_req_i.dat, wb_req_i.sel);
          s_d.pin_edge_select = wv[N-1:0];
        end
        OFS_CTRL: begin
          wv = merge({27'h0000000, s_q.ctrl}, wb_req_i.dat, wb_req_i.sel);
          s_d.ctrl = wv[CTRL_POL:CTRL_EN];
        end
        OFS_TRIGSEL: begin
          wv = merge({29'h00000000, s_q.trigger_source_select}, wb_req_i.dat, wb_req_i.sel);
          s_d.trigger_source_select = wv[TRIGSEL_W-1:0];
        end
        OFS_RELOAD: begin
          s_d.reload_value = merge(s_q.reload_value, wb_req_i.dat, wb_req_i.sel);
        end
        default: begin
        end
      endcase
    end

    // Set and clear masks act only on the lanes that were selected.
    // The clear is applied after the set, so the clear wins on a shared bit.
    // No read-modify-write is needed, so an interrupt between a read and a
    // write elsewhere in software can never undo another pin's change.
    if (wr && wb_req_i.adr == OFS_MODIFY) begin
      wv    = wb_req_i.dat & wmask;
      set_m = wv[SET_LSB +: N];
      clr_m = wv[CLR_LSB +: N];
      s_d.drive_level = (s_q.drive_level | set_m) & ~clr_m;
    end

    if (rd) begin
      case (wb_req_i.adr)
        OFS_OE:      s_d.rdata = {24'h000000, s_q.pin_output_enable};
        OFS_DRIVE:   s_d.rdata = {24'h000000, s_q.drive_level};
        OFS_SAMPLE:  s_d.rdata = {24'h000000, stable};
        OFS_TRIGEN:  s_d.rdata = {24'h000000, s_q.pin_trigger_enable};
        OFS_IRQEN:   s_d.rdata = {24'h000000, s_q.pin_interrupt_enable};
        OFS_EDGE:    s_d.rdata = {24'h000000, s_q.pin_edge_select};
        OFS_FLAGS:   s_d.rdata = {24'h000000, s_q.pin_interrupt_flags};
        OFS_CTRL:    s_d.rdata = {26'h0000000, s_q.overflow, s_q.ctrl};
        OFS_TRIGSEL: s_d.rdata = {29'h00000000, s_q.trigger_source_select};
        OFS_COUNT:   s_d.rdata = s_q.count_value;
        OFS_RELOAD:  s_d.rdata = s_q.reload_value;
        default:     s_d.rdata = ZERO32;
      endcase
    end

    // Pin interrupt flags: a read clears them, a new edge in that same cycle survives.
    // Setting after clearing means that no edge is ever lost to a read.
    // Output pins are masked, so driving a pin never raises its own flag.
    edge_hit = s_q.pin_interrupt_enable & ~s_q.pin_output_enable
             & ((rise & s_q.pin_edge_select) | (fall & ~s_q.pin_edge_select));
    if (rd && wb_req_i.adr == OFS_FLAGS) begin
      s_d.pin_interrupt_flags = ZERO8;
    end
    s_d.pin_interrupt_flags = s_d.pin_interrupt_flags | edge_hit;

    // Trigger of the selected pin: edge or level, shaped by polarity.
    // An edge trigger is active for one cycle per edge, a level trigger
    // for every cycle in which the synchronised level matches the polarity.
    // A pin that is not enabled as a trigger, or is an output, never counts.
    sel_pin = trig_out[s_q.trigger_source_select];
    if (s_q.ctrl.level_not_edge) begin
      active = s_q.ctrl.polarity_select ? stable[s_q.trigger_source_select]
                                        : ~stable[s_q.trigger_source_select];
    end else begin
      active = s_q.ctrl.polarity_select ? rise[s_q.trigger_source_select]
                                        : fall[s_q.trigger_source_select];
    end
    active = active & sel_pin;

    // Clock mode steps every cycle and ignores the trigger shape.
    step = s_q.ctrl.enable & (s_q.ctrl.count_source_select ? active : 1'b1);
    s_d.overflow = 1'b0;
    if (step) begin
      if (s_q.count_value == COUNT_MAX) begin
        s_d.count_value = s_q.reload_value;
        s_d.overflow    = 1'b1;
        if (s_q.ctrl.stop_on_wrap) begin
          s_d.ctrl.enable = 1'b0;
        end
      end else begin
        s_d.count_value = s_q.count_value + 32'h0000_0001;
      end
    end

    // Software write to the count wins over the hardware step.
    // The overflow pulse of a wrap in that same cycle still goes out, so
    // a wrap is reported even when software rewrites the count at once.
    if (wr && wb_req_i.adr == OFS_COUNT) begin
      s_d.count_value = merge(s_q.count_value, wb_req_i.dat, wb_req_i.sel);
    end
  end

  // All state resets to constants; every pin starts as an input.
  // Zero for the direction register means no pin is driven after reset,
  // and zero flags and control mean no line is raised and the timer rests.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flip-flops, so no pin glitches between edges.
  // The drive level is shown even on inputs; the enable decides whether
  // it reaches the pin, which lets software preload it before switching.
  assign pin_o        = s_q.drive_level;
  assign pin_oe_o     = s_q.pin_output_enable;
  assign wb_rsp_o.ack = s_q.ack;
  assign wb_rsp_o.dat = s_q.rdata;

  // Interrupt lines: timer pulses on its line, port flags hold a level on theirs.
  // The port line stays high until software reads the flags register.
  always_comb begin
    irq_o            = '0;
    irq_o[IRQ_TIMER] = s_q.overflow;
    irq_o[IRQ_PORT]  = |s_q.pin_interrupt_flags;
  end

endmodule // gpio_timer

`default_nettype wire

//--- gpio_timer_monitor.sv
// Checker for the port: bus answer, pin outputs and interrupt lines.
// Assumes it is bound to every gpio_timer instance and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module gpio_timer_monitor
  import gpio_timer_pkg::*;
#(
  parameter int N = NUM_PINS
) (
  // Clock and reset.
  input wire logic                 clk_i,
  input wire logic                 rst_n_i,
  // Bus.
  input wire wb_req_t              wb_req_i,
  input wire wb_rsp_t              wb_rsp_o,
  // Pins and lines.
  input wire logic [N-1:0]         pin_i,
  input wire logic [N-1:0]         pin_o,
  input wire logic [N-1:0]         pin_oe_o,
  input wire logic [IRQ_LINES-1:0] irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic       wr_ok;
  logic [3:0] quiet_q;
  // A write lands only at the edge that takes the request.
  assign wr_ok = wb_req_i.cyc & wb_req_i.stb & wb_req_i.we & !wb_rsp_o.ack;
  // Cycles since a pin moved; it saturates so an old edge never looks fresh.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) quiet_q <= 4'hf;
    else if (pin_i != $past(pin_i)) quiet_q <= 4'h0;
    else if (quiet_q != 4'hf) quiet_q <= quiet_q + 4'h1;
  end
  // The request and its one-cycle answer.
  sequence taken_s;
    wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack;
  endsequence
  sequence answer_s;
    wb_rsp_o.ack ##1 !wb_rsp_o.ack;
  endsequence
  ack_latency_a: assert property (taken_s |=> answer_s)
    else $error("bus answer not one cycle after request");
  idle_data_a: assert property (!wb_rsp_o.ack |-> wb_rsp_o.dat == ZERO32)
    else $error("read data not zero outside ack");
  modify_read_a: assert property (wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack
    && wb_req_i.adr == OFS_MODIFY |=>
    wb_rsp_o.dat == ZERO32) else $error("modify register read not zero");
  spare_lines_a: assert property (irq_o[3:0] == 4'h0)
    else $error("unused interrupt line active");
  ovf_pulse_a: assert property (irq_o[IRQ_TIMER] |=> !irq_o[IRQ_TIMER])
    else $error("timer line longer than one cycle");
  dir_write_a: assert property ($changed(pin_oe_o) |-> $past(wr_ok &&
    wb_req_i.adr == OFS_OE)) else $error("direction moved without write");
  drive_write_a: assert property ($changed(pin_o) |-> $past(wr_ok &&
    (wb_req_i.adr == OFS_DRIVE || wb_req_i.adr == OFS_MODIFY)))
    else $error("drive level moved without write");
  port_irq_a: assert property ($rose(irq_o[IRQ_PORT]) |-> quiet_q < 4'h8)
    else $error("port line rose without pin edge");
endmodule : gpio_timer_monitor
bind gpio_timer gpio_timer_monitor #(.N(N)) i_mon (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o), .pin_i(pin_i), .pin_o(pin_o),
  .pin_oe_o(pin_oe_o), .irq_o(irq_o));
`default_nettype wire

//--- pin_model.sv
// Far side of the eight pins: outside drivers and pull-downs.
// Assumes the bench chooses the outside levels.
`timescale 1ns/1ps
`default_nettype none
module pin_model (
  // Port side.
  input  wire logic [7:0] pin_o,
  input  wire logic [7:0] pin_oe_o,
  // Outside drivers.
  input  wire logic [7:0] ext_i,
  input  wire logic [7:0] ext_en_i,
  // Level seen by the port.
  output logic      [7:0] pin_i
);
  // An undriven pin falls to its pull-down instead of holding a stale level.
  assign pin_i = (pin_oe_o & pin_o) | (~pin_oe_o & ext_en_i & ext_i);
endmodule : pin_model
`default_nettype wire

//--- gpio_timer_tb.sv
// Bench for the port: bus calls with expected values.
// Assumes the package, the design, the pin model and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module gpio_timer_tb;
  import gpio_timer_pkg::*;
  logic        clk_i;
  logic        rst_n_i;
  wb_req_t     req;
  wb_rsp_t     rsp;
  logic [7:0]  pin_i;
  logic [7:0]  pin_o;
  logic [7:0]  pin_oe_o;
  logic [7:0]  ext;
  logic [5:0]  irq_o;
  logic [31:0] rd;
  int          num_errors;
  int          samples_checked;
  int          cyc_n;
  gpio_timer i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .wb_req_i(req), .wb_rsp_o(rsp),
    .pin_i(pin_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o), .irq_o(irq_o));
  pin_model i_pins (.pin_o(pin_o), .pin_oe_o(pin_oe_o), .ext_i(ext), .ext_en_i(8'hff),
    .pin_i(pin_i));
  // Clock at 100 ns period.
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  task automatic end_sim();
    if (num_errors == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One classic cycle; the request stays until ack is seen at an edge.
  task automatic wb(input logic we, input logic [7:0] a, input logic [3:0] s,
                    input logic [31:0] d);
    @(posedge clk_i);
    req <= '{1'b1, 1'b1, we, a, s, d};
    do @(posedge clk_i); while (rsp.ack !== 1'b1);
    rd = rsp.dat;
    req <= '0;
  endtask
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, 4'hf, d);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 4'hf, ZERO32);
    chk(rd, exp);
  endtask
  // Six cycles cover the three-stage input path plus the flag register.
  task automatic pins(input logic [7:0] v);
    @(posedge clk_i);
    ext <= v;
    repeat (6) @(posedge clk_i);
  endtask
  task automatic wait_ovf();
    for (int i = 0; i < 40 && irq_o[IRQ_TIMER] !== 1'b1; i++) @(posedge clk_i);
    chk(32'(irq_o[IRQ_TIMER]), 32'h1);
  endtask
  // A hang counts as a mismatch and ends the run.
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n > 5000) begin
      num_errors++;
      end_sim();
    end
  end
  initial begin
    rst_n_i = 1'b0;
    req = '0;
    ext = 8'h00;
    num_errors = 0;
    samples_checked = 0;
    cyc_n = 0;
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    chk({16'h0, pin_oe_o, pin_o}, ZERO32);
    w(OFS_DRIVE, 32'h0000_00a5);
    w(OFS_OE, 32'h0000_000f);
    chk({16'h0, pin_oe_o, pin_o}, 32'h0000_0fa5);
    wb(1'b1, OFS_MODIFY, 4'h5, 32'h0005_0051);
    chk(32'(pin_o), 32'h0000_00f0);
    wb(1'b1, OFS_DRIVE, 4'h1, 32'hffff_ff3c);
    rc(OFS_DRIVE, 32'h0000_003c);
    pins(8'h90);
    rc(OFS_SAMPLE, 32'h0000_009c);
    rc(8'h40, ZERO32);
    w(OFS_OE, ZERO32);
    pins(8'h00);
    w(OFS_EDGE, 32'h4);
    w(OFS_TRIGEN, 32'h4);
    w(OFS_IRQEN, 32'h4);
    w(OFS_TRIGEN, ZERO32);
    pins(8'h04);
    chk(32'(irq_o[IRQ_PORT]), 32'h1);
    rc(OFS_FLAGS, 32'h4);
    rc(OFS_FLAGS, ZERO32);
    chk(32'(irq_o[IRQ_PORT]), ZERO32);
    pins(8'h02);
    rc(OFS_FLAGS, ZERO32);
    w(OFS_RELOAD, 32'h5);
    w(OFS_COUNT, 32'hffff_fffd);
    w(OFS_CTRL, 32'h5);
    wait_ovf();
    rc(OFS_COUNT, 32'h5);
    rc(OFS_CTRL, 32'h4);
    w(OFS_COUNT, ZERO32);
    w(OFS_TRIGSEL, 32'h3);
    w(OFS_TRIGEN, 32'h8);
    for (int p = 0; p < 2; p++) begin
      w(OFS_CTRL, p ? 32'h03 : 32'h13);
      repeat (3) begin
        pins(8'h08);
        pins(8'h00);
      end
      rc(OFS_COUNT, p ? 32'h6 : 32'h3);
    end
    w(OFS_CTRL, 32'h1b);
    pins(8'h00);
    rc(OFS_COUNT, 32'h6);
    w(OFS_CTRL, ZERO32);
    pins(8'h00);
    rc(OFS_COUNT, 32'h6);
    w(OFS_COUNT, 32'hffff_fff0);
    w(OFS_CTRL, 32'h1d);
    wait_ovf();
    rc(OFS_COUNT, 32'h5);
    end_sim();
  end
endmodule : gpio_timer_tb
`default_nettype wire
